// file: verilog/asq_top.sv
// channel sequencer, conversion control and serial register port
`timescale 1ns/1ps
`include "asq_consts.svh"
module asq_top #(
  parameter int SETTLE_CYCLES = 64,
  parameter int WAKE_CYCLES = (`ASQ_OSC_NS + `ASQ_CLK_NS - 1) / `ASQ_CLK_NS
) (
  // core clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // serial port
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT_RDY,
  output logic DOUT_RDY_OE_N,
  // filter side
  input wire logic [23:0] RESULT_DATA,
  output logic FILTER_RESET,
  output logic [2:0] ACTIVE_CHANNEL,
  output logic CONVERTER_ON
);
  if (SETTLE_CYCLES < 3 || WAKE_CYCLES < 2)
  begin : g_bad
    $error("asq_top: settle or wake count too small");
  end

  localparam asq_pkg::asq_core_s CORE_RST = '{
    st: asq_pkg::ASQ_SETTLE, cnt: 32'(SETTLE_CYCLES), chan: 3'h0,
    rdy_n: 1'b1, word: '0, mode: `ASQ_MODE_RST, conf: `ASQ_CONF_RST,
    nt: 1'b0, wt_s: 3'h0, rt_s: 3'h0, sh_s: 2'h0, db_s: 2'h0,
    cs_s: 2'h3, dout: 1'b1, oe_n: 1'b1, frst: 1'b0, on: 1'b1};

  // next enabled channel after c, wrapping; nearest wins
  function automatic logic [2:0] nxt_chan(input logic [7:0] en,
                                          input logic [2:0] c);
    logic [2:0] r;
    logic [2:0] k;
    r = c;
    for (int i = 8; i >= 1; i--)
    begin
      k = c + 3'(i);
      if (en[k])
        r = k;
    end
    return r;
  endfunction

  logic [1:0] crst_ff;
  logic [1:0] lrst_ff;
  asq_pkg::asq_core_s c_ff;
  asq_pkg::asq_core_s nxt_c;
  asq_pkg::asq_link_s l_ff;
  asq_pkg::asq_link_s nxt_l;
  logic [7:0] en;
  logic [2:0] nxt_ch;
  logic last;
  logic single;
  logic [2:0] md;
  logic [7:0] cbyte;
  logic [2:0] ra;
  logic [31:0] rd_word;
  logic [5:0] rd_len;

  // reset release on each clock
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      crst_ff <= 2'h0;
    else
      crst_ff <= {crst_ff[0], 1'b1};
  end

  always_ff @(posedge SCLK or negedge RST_N)
  begin
    if (!RST_N)
      lrst_ff <= 2'h0;
    else
      lrst_ff <= {lrst_ff[0], 1'b1};
  end

  // sequencer helpers
  assign en = c_ff.conf[`ASQ_CH_HI:`ASQ_CH_LO];
  assign nxt_ch = nxt_chan(en, c_ff.chan);
  assign last = (nxt_ch <= c_ff.chan);
  assign single = (c_ff.mode[`ASQ_MD_HI:`ASQ_MD_LO] == `ASQ_MD_SINGLE);
  assign md = l_ff.mode[`ASQ_MD_HI:`ASQ_MD_LO];

  // core side: sequencer, ready, pin drive
  always_comb
  begin
    nxt_c = c_ff;
    nxt_c.frst = 1'b0;
    nxt_c.wt_s = {c_ff.wt_s[1:0], l_ff.wt};
    nxt_c.rt_s = {c_ff.rt_s[1:0], l_ff.rt};
    nxt_c.sh_s = {c_ff.sh_s[0], l_ff.sh};
    nxt_c.db_s = {c_ff.db_s[0], l_ff.osr[31]};
    nxt_c.cs_s = {c_ff.cs_s[0], CS_N};
    if (c_ff.rt_s[2] != c_ff.rt_s[1])
      nxt_c.rdy_n = 1'b1;
    unique case (c_ff.st)
      asq_pkg::ASQ_DOWN:
        nxt_c.on = 1'b0;
      asq_pkg::ASQ_WAKE:
      begin
        nxt_c.cnt = c_ff.cnt - 32'h1;
        if (c_ff.cnt == 32'h1)
        begin
          nxt_c.st = asq_pkg::ASQ_SETTLE;
          nxt_c.cnt = 32'(SETTLE_CYCLES);
          nxt_c.frst = 1'b1;
        end
      end
      asq_pkg::ASQ_SETTLE:
      begin
        nxt_c.cnt = c_ff.cnt - 32'h1;
        if (c_ff.cnt == 32'h2)
          nxt_c.rdy_n = 1'b1;
        if (c_ff.cnt == 32'h1)
          nxt_c.st = asq_pkg::ASQ_STORE;
      end
      asq_pkg::ASQ_STORE:
      begin
        nxt_c.word.result = RESULT_DATA;
        nxt_c.word.status = {1'b0, 3'h0, 1'b0, c_ff.chan};
        nxt_c.rdy_n = 1'b0;
        nxt_c.nt = ~c_ff.nt;
        if (single && last)
        begin
          nxt_c.st = asq_pkg::ASQ_DOWN;
          nxt_c.on = 1'b0;
        end
        else
        begin
          nxt_c.chan = nxt_ch;
          nxt_c.frst = 1'b1;
          nxt_c.st = asq_pkg::ASQ_SETTLE;
          nxt_c.cnt = 32'(SETTLE_CYCLES);
        end
      end
    endcase
    // register write or interface reset restarts conversions, or powers down if no run mode or no channel is enabled
    if (c_ff.wt_s[2] != c_ff.wt_s[1])
    begin
      nxt_c.mode = l_ff.mode;
      nxt_c.conf = l_ff.conf;
      if ((md == `ASQ_MD_CONT || md == `ASQ_MD_SINGLE) &&
          l_ff.conf[`ASQ_CH_HI:`ASQ_CH_LO] != 8'h0)
      begin
        nxt_c.chan = nxt_chan(l_ff.conf[`ASQ_CH_HI:`ASQ_CH_LO], 3'h7);
        nxt_c.st = (md == `ASQ_MD_SINGLE) ? asq_pkg::ASQ_WAKE
                                          : asq_pkg::ASQ_SETTLE;
        nxt_c.cnt = (md == `ASQ_MD_SINGLE) ? 32'(WAKE_CYCLES)
                                           : 32'(SETTLE_CYCLES);
        nxt_c.rdy_n = 1'b1;
        nxt_c.frst = 1'b1;
        nxt_c.on = 1'b1;
      end
      else
      begin
        nxt_c.st = asq_pkg::ASQ_DOWN;
        nxt_c.on = 1'b0;
      end
    end
    // shared line: released while deselected, data while shifting, else ready
    nxt_c.oe_n = c_ff.cs_s[1];
    nxt_c.dout = c_ff.cs_s[1] ? 1'b1 :
                 (c_ff.sh_s[1] ? c_ff.db_s[1] : c_ff.rdy_n);
  end

  always_ff @(posedge CORE_CLK or negedge crst_ff[1])
  begin
    if (!crst_ff[1])
      c_ff <= CORE_RST;
    else
      c_ff <= nxt_c;
  end

  // read source by address
  assign cbyte = {l_ff.cb[6:0], DIN};
  assign ra = l_ff.cread ? `ASQ_A_DATA : cbyte[`ASQ_CB_AHI:`ASQ_CB_ALO];
  always_comb
  begin
    rd_word = 32'h0;
    rd_len = `ASQ_LEN_BYTE;
    case (ra)
      `ASQ_A_STATUS:
        rd_word = {c_ff.rdy_n, c_ff.word.status[6:0], 24'h0};
      `ASQ_A_MODE:
      begin
        rd_word = {l_ff.mode, 8'h0};
        rd_len = `ASQ_LEN_REG;
      end
      `ASQ_A_CONF:
      begin
        rd_word = {l_ff.conf, 8'h0};
        rd_len = `ASQ_LEN_REG;
      end
      `ASQ_A_DATA:
      begin
        rd_word = c_ff.word;
        rd_len = l_ff.mode[`ASQ_MD_STA] ? `ASQ_LEN_STA
                                        : `ASQ_LEN_REG;
      end
      default:
        rd_word = 32'h0;
    endcase
  end

  // serial side: command decode, shifting, interface reset
  always_comb
  begin
    nxt_l = l_ff;
    nxt_l.nt_s = {l_ff.nt_s[1:0], c_ff.nt};
    if (l_ff.nt_s[2] != l_ff.nt_s[1])
      nxt_l.armed = 1'b1;
    if (l_ff.sh)
    begin
      nxt_l.osr = {l_ff.osr[30:0], 1'b0};
      nxt_l.ocnt = l_ff.ocnt - 6'h1;
      if (l_ff.ocnt == 6'h1)
      begin
        nxt_l.sh = 1'b0;
        nxt_l.st = asq_pkg::ASQ_CMD;
        if (l_ff.rdd)
          nxt_l.rt = ~l_ff.rt;
      end
    end
    if (CS_N)
    begin
      nxt_l.st = asq_pkg::ASQ_CMD;
      nxt_l.bits = 3'h0;
      nxt_l.sh = 1'b0;
      nxt_l.ones = 6'h0;
    end
    else if (DIN && l_ff.ones == `ASQ_RESET_ONES - 6'h1)
    begin
      nxt_l.st = asq_pkg::ASQ_CMD;
      nxt_l.bits = 3'h0;
      nxt_l.sh = 1'b0;
      nxt_l.ones = 6'h0;
      nxt_l.cread = 1'b0;
      nxt_l.armed = 1'b0;
      nxt_l.mode = `ASQ_MODE_RST;
      nxt_l.conf = `ASQ_CONF_RST;
      nxt_l.wt = ~l_ff.wt;
    end
    else
    begin
      nxt_l.ones = DIN ? l_ff.ones + 6'h1 : 6'h0;
      unique case (l_ff.st)
        asq_pkg::ASQ_CMD:
        begin
          nxt_l.cb = cbyte;
          nxt_l.bits = l_ff.bits + 3'h1;
          if (l_ff.cread && l_ff.armed && !l_ff.sh &&
              l_ff.bits == 3'h0)
          begin
            nxt_l.osr = rd_word;
            nxt_l.ocnt = rd_len;
            nxt_l.sh = 1'b1;
            nxt_l.rdd = 1'b1;
            nxt_l.armed = 1'b0;
          end
          if (l_ff.bits == 3'h7 && l_ff.cread)
          begin
            if (cbyte == `ASQ_CB_EXIT)
              nxt_l.cread = 1'b0;
          end
          else if (l_ff.bits == 3'h7 && !cbyte[`ASQ_CB_WEN])
          begin
            nxt_l.addr = cbyte[`ASQ_CB_AHI:`ASQ_CB_ALO];
            if (cbyte[`ASQ_CB_RD] && ra == `ASQ_A_DATA &&
                cbyte[`ASQ_CB_CREAD])
            begin
              nxt_l.cread = 1'b1;
              nxt_l.armed = 1'b0;
            end
            else if (cbyte[`ASQ_CB_RD])
            begin
              nxt_l.st = asq_pkg::ASQ_RDATA;
              nxt_l.osr = rd_word;
              nxt_l.ocnt = rd_len;
              nxt_l.sh = 1'b1;
              nxt_l.rdd = (ra == `ASQ_A_DATA);
            end
            else
            begin
              nxt_l.st = asq_pkg::ASQ_WDATA;
              nxt_l.wcnt = (ra == `ASQ_A_MODE || ra == `ASQ_A_CONF)
                           ? `ASQ_WLEN_REG : `ASQ_WLEN_BYTE;
            end
          end
        end
        asq_pkg::ASQ_WDATA:
        begin
          nxt_l.win = {l_ff.win[22:0], DIN};
          nxt_l.wcnt = l_ff.wcnt - 5'h1;
          if (l_ff.wcnt == 5'h1)
          begin
            nxt_l.st = asq_pkg::ASQ_CMD;
            nxt_l.bits = 3'h0;
            if (l_ff.addr == `ASQ_A_MODE)
              nxt_l.mode = {l_ff.win[22:0], DIN};
            if (l_ff.addr == `ASQ_A_CONF)
              nxt_l.conf = {l_ff.win[22:0], DIN};
            if (l_ff.addr == `ASQ_A_MODE || l_ff.addr == `ASQ_A_CONF)
              nxt_l.wt = ~l_ff.wt;
          end
        end
        asq_pkg::ASQ_RDATA:
          nxt_l.bits = 3'h0;
        default:
          nxt_l.st = asq_pkg::ASQ_CMD;
      endcase
    end
  end

  always_ff @(posedge SCLK or negedge lrst_ff[1])
  begin
    if (!lrst_ff[1])
    begin
      l_ff <= '0;
      l_ff.mode <= `ASQ_MODE_RST;
      l_ff.conf <= `ASQ_CONF_RST;
    end
    else
      l_ff <= nxt_l;
  end

  // outputs straight from flops
  assign DOUT_RDY = c_ff.dout;
  assign DOUT_RDY_OE_N = c_ff.oe_n;
  assign FILTER_RESET = c_ff.frst;
  assign ACTIVE_CHANNEL = c_ff.chan;
  assign CONVERTER_ON = c_ff.on;

  // checks
  sequence s_settle_end;
    c_ff.st == asq_pkg::ASQ_SETTLE && c_ff.cnt == 32'h2;
  endsequence
  sequence s_store_low;
    c_ff.st == asq_pkg::ASQ_STORE ##1 !c_ff.rdy_n;
  endsequence
  property p_rdy_cycle;
    @(posedge CORE_CLK) disable iff (!crst_ff[1])
    s_settle_end |=> c_ff.rdy_n ##1 s_store_low;
  endproperty
  a_rdy_cycle: assert property (p_rdy_cycle)
    else $error("ready not raised then lowered around update");
  property p_switch;
    @(posedge CORE_CLK) disable iff (!crst_ff[1])
    c_ff.st == asq_pkg::ASQ_STORE && !(single && last) &&
    c_ff.wt_s[2] == c_ff.wt_s[1]
    |=> FILTER_RESET && c_ff.st == asq_pkg::ASQ_SETTLE &&
        c_ff.cnt == 32'(SETTLE_CYCLES);
  endproperty
  a_switch: assert property (p_switch)
    else $error("channel switch without filter reset");
  // enable bits that a move from channel o to channel n passes over
  function automatic logic [7:0] skipped(input logic [2:0] n,
                                         input logic [2:0] o);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = (8'h1 << n) - 8'h1;
    hi = ~((8'h2 << o) - 8'h1);
    return (n > o) ? (lo & hi) : (lo | hi);
  endfunction
  property p_wrap;
    @(posedge CORE_CLK) disable iff (!crst_ff[1])
    c_ff.st == asq_pkg::ASQ_STORE && !single &&
    c_ff.wt_s[2] == c_ff.wt_s[1]
    |=> en[c_ff.chan] &&
        (en & skipped(c_ff.chan, $past(c_ff.chan))) == 8'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("sequencer skipped an enabled channel");
  property p_single_end;
    @(posedge CORE_CLK) disable iff (!crst_ff[1])
    c_ff.st == asq_pkg::ASQ_STORE && single && last &&
    c_ff.wt_s[2] == c_ff.wt_s[1]
    |=> !CONVERTER_ON ##1 c_ff.st == asq_pkg::ASQ_DOWN;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single sequence did not power down");
  property p_chan_status;
    @(posedge CORE_CLK) disable iff (!crst_ff[1])
    c_ff.st == asq_pkg::ASQ_STORE
    |=> c_ff.word.status[3:0] == {1'b0, $past(c_ff.chan)};
  endproperty
  a_chan_status: assert property (p_chan_status)
    else $error("status nibble does not name the channel");
  property p_deselect;
    @(posedge CORE_CLK) disable iff (!crst_ff[1])
    c_ff.cs_s[1] |=> DOUT_RDY && DOUT_RDY_OE_N;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("line driven while deselected");
  property p_ready_pin;
    @(posedge CORE_CLK) disable iff (!crst_ff[1])
    !c_ff.cs_s[1] && !c_ff.sh_s[1] |=> DOUT_RDY == $past(c_ff.rdy_n);
  endproperty
  a_ready_pin: assert property (p_ready_pin)
    else $error("line does not follow ready");
  property p_ones_reset;
    @(posedge SCLK) disable iff (!lrst_ff[1])
    !CS_N && DIN && l_ff.ones == `ASQ_RESET_ONES - 6'h1
    |=> l_ff.mode == `ASQ_MODE_RST && l_ff.conf == `ASQ_CONF_RST &&
        l_ff.st == asq_pkg::ASQ_CMD && !l_ff.cread;
  endproperty
  a_ones_reset: assert property (p_ones_reset)
    else $error("forty ones did not reset the interface");
endmodule

// file: verilog/asq_consts.svh
// constants of the converter sequencer and serial control
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH
// communications byte fields
`define ASQ_CB_WEN 7
`define ASQ_CB_RD 6
`define ASQ_CB_AHI 5
`define ASQ_CB_ALO 3
`define ASQ_CB_CREAD 2
`define ASQ_CB_EXIT 8'h58
// register addresses
`define ASQ_A_STATUS 3'h0
`define ASQ_A_MODE 3'h1
`define ASQ_A_CONF 3'h2
`define ASQ_A_DATA 3'h3
// mode register fields
`define ASQ_MD_HI 23
`define ASQ_MD_LO 21
`define ASQ_MD_STA 20
`define ASQ_MD_CONT 3'h0
`define ASQ_MD_SINGLE 3'h1
`define ASQ_MODE_RST 24'h000000
// configuration register fields
`define ASQ_CH_HI 15
`define ASQ_CH_LO 8
`define ASQ_CONF_RST 24'h000100
// status byte
`define ASQ_ST_RDY 7
// serial counts
`define ASQ_RESET_ONES 6'h28
`define ASQ_LEN_REG 6'h18
`define ASQ_LEN_STA 6'h20
`define ASQ_LEN_BYTE 6'h08
`define ASQ_WLEN_REG 5'h18
`define ASQ_WLEN_BYTE 5'h08
// timing
`define ASQ_OSC_NS 1000000
`define ASQ_CLK_NS 20
`endif

// file: verilog/asq_pkg.sv
// types of the converter sequencer and serial control
package asq_pkg;
  typedef enum logic [1:0] {ASQ_DOWN, ASQ_WAKE, ASQ_SETTLE, ASQ_STORE}
    asq_conv_e;
  typedef enum logic [1:0] {ASQ_CMD, ASQ_WDATA, ASQ_RDATA} asq_ser_e;
  // one conversion word with its status byte
  typedef struct packed {
    logic [23:0] result;
    logic [7:0] status;
  } asq_word_s;
  // state on the core clock
  typedef struct packed {
    asq_conv_e st;
    logic [31:0] cnt;
    logic [2:0] chan;
    logic rdy_n;
    asq_word_s word;
    logic [23:0] mode;
    logic [23:0] conf;
    logic nt;
    logic [2:0] wt_s;
    logic [2:0] rt_s;
    logic [1:0] sh_s;
    logic [1:0] db_s;
    logic [1:0] cs_s;
    logic dout;
    logic oe_n;
    logic frst;
    logic on;
  } asq_core_s;
  // state on the serial clock
  typedef struct packed {
    asq_ser_e st;
    logic [2:0] bits;
    logic [4:0] wcnt;
    logic [7:0] cb;
    logic [23:0] win;
    logic [2:0] addr;
    logic cread;
    logic [5:0] ones;
    logic [23:0] mode;
    logic [23:0] conf;
    logic wt;
    logic rt;
    logic [2:0] nt_s;
    logic armed;
    logic sh;
    logic [31:0] osr;
    logic [5:0] ocnt;
    logic rdd;
  } asq_link_s;
endpackage

// file: test/asq_host.sv
// serial host model: drives clock, select and data in
`timescale 1ns/1ps
module asq_host (
  // serial lines to the device
  output logic sclk,
  output logic cs_n,
  output logic din,
  // shared data and ready line, resolved
  input wire logic line
);
  // clock idles high, device deselected, data held low
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // one frame of n bits, msb first; clock stands still outside frames
  task automatic shift(input logic [31:0] tx, input int n,
    output logic [31:0] rx);
    rx = 32'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'b0;
      din = (i < 32) ? tx[i] : 1'b0;
      #80;
      rx = {rx[30:0], line};
      sclk = 1'b1;
      #80;
    end
    din = 1'b0;
  endtask

  // chip select held low for three-wire use
  task automatic sel(input logic v);
    cs_n = v;
    #80;
  endtask

  // command byte, then the selected register access
  task automatic access(input logic [7:0] cb, input logic [31:0] tx,
    input int n, output logic [31:0] rx);
    shift({24'h0, cb}, 8, rx);
    shift(tx, n, rx);
  endtask

  // forty ones, then the quiet period before the next access
  task automatic if_reset();
    logic [31:0] rx;
    shift(32'hffffffff, 32, rx);
    shift(32'h000000ff, 8, rx);
    #500000;
  endtask
endmodule

// file: test/asq_top_tb_top.sv
// self-checking bench of the converter sequencer and serial control
`timescale 1ns/1ps
module asq_top_tb_top;
  localparam int SETTLE = 800;
  localparam int WAKE = 40;
  logic core_clk;
  logic rst_n;
  logic [23:0] res_data;
  logic dout_rdy;
  logic dout_oe_n;
  logic [2:0] act_ch;
  logic conv_on;
  logic frst;
  int n_frst = 0;
  wire sclk;
  wire cs_n;
  wire din;
  wire line;
  int n_fail;
  int check_count;

  // released line is pulled up
  assign line = dout_oe_n ? 1'b1 : dout_rdy;

  asq_top #(.SETTLE_CYCLES(SETTLE), .WAKE_CYCLES(WAKE)) u_asq_top (
    .CORE_CLK(core_clk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n),
    .DIN(din), .DOUT_RDY(dout_rdy), .DOUT_RDY_OE_N(dout_oe_n),
    .RESULT_DATA(res_data), .FILTER_RESET(frst), .ACTIVE_CHANNEL(act_ch),
    .CONVERTER_ON(conv_on)
  );

  asq_host u_asq_host (.sclk(sclk), .cs_n(cs_n), .din(din), .line(line));

  // core clock, 20 ns
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // filter side: result word carries the channel being converted
  always @(posedge core_clk)
    res_data <= {16'hc3a0, 5'h00, act_ch};

  // count filter reset pulses
  always @(posedge core_clk)
    if (frst === 1'b1)
      n_frst <= n_frst + 1;

  function automatic logic [23:0] res_of(input int ch);
    return {16'hc3a0, 5'h00, ch[2:0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bounded wait for a fresh ready low, so a read never meets an update
  task automatic wait_rdy();
    int k;
    k = 0;
    while (line === 1'b0 && k < 2000)
    begin
      @(negedge core_clk);
      k++;
    end
    if (line === 1'b0)
    begin
      n_fail++;
      $display("BAD ready release expected 1 seen 0");
      end_sim();
    end
    k = 0;
    while (line !== 1'b0 && k < 20000)
    begin
      @(negedge core_clk);
      k++;
    end
    if (line !== 1'b0)
    begin
      n_fail++;
      $display("BAD ready wait expected 0 seen timeout");
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] cb, input logic [23:0] v);
    logic [31:0] rx;
    u_asq_host.access(cb, {8'h0, v}, 24, rx);
    repeat (10) @(negedge core_clk);
  endtask

  // read the data word, judge result, channel and ready
  task automatic rd_word(input int ch, input int n);
    logic [31:0] rx;
    u_asq_host.access(8'h58, 32'h0, n, rx);
    repeat (10) @(negedge core_clk);
    chk("ready after read", 32'h1, {31'h0, line});
    if (n == 32)
    begin
      chk("result", {8'h0, res_of(ch)}, {8'h0, rx[31:8]});
      chk("status channel", ch, {28'h0, rx[3:0]});
      chk("status ready", 32'h0, {31'h0, rx[7]});
    end
    else
      chk("result", {8'h0, res_of(ch)}, rx);
  endtask

  task automatic t_power_up();
    logic [31:0] rx;
    wait_rdy();
    chk("channel at start", 32'h0, {29'h0, act_ch});
    rd_word(0, 24);
    rd_word(0, 24);
    u_asq_host.access(8'h40, 32'h0, 8, rx);
    chk("status byte", 32'h80, rx);
    u_asq_host.access(8'h68, 32'h0, 8, rx);
    chk("unmapped read", 32'h0, rx);
    $display("test power_up done");
  endtask

  task automatic t_sequence();
    logic [31:0] rx;
    int f0;
    int chs[4] = '{1, 3, 6, 1};
    f0 = 0;
    wr(8'h10, 24'h004a00);
    wr(8'h08, 24'h100000);
    u_asq_host.access(8'h50, 32'h0, 24, rx);
    chk("channel enables", 32'h004a00, rx);
    foreach (chs[i])
    begin
      wait_rdy();
      if (i == 0)
        f0 = n_frst;
      rd_word(chs[i], 32);
    end
    chk("filter resets", 32'h3, n_frst - f0);
    $display("test sequence done");
  endtask

  task automatic t_single();
    int chs[3] = '{1, 3, 6};
    time t0;
    wr(8'h08, 24'h300000);
    t0 = $time;
    chk("converter on", 32'h1, {31'h0, conv_on});
    foreach (chs[i])
    begin
      wait_rdy();
      if (i == 0)
        chk("wake delay", 32'h1,
          {31'h0, ($time - t0) >= (WAKE + SETTLE - 20) * 20});
      rd_word(chs[i], 32);
    end
    chk("powered down", 32'h0, {31'h0, conv_on});
    repeat (2000) @(posedge core_clk);
    chk("ready held high", 32'h1, {31'h0, line});
    $display("test single done");
  endtask

  task automatic t_cread();
    logic [31:0] rx;
    int chs[2] = '{1, 3};
    wr(8'h08, 24'h100000);
    u_asq_host.shift(32'h5c, 8, rx);
    foreach (chs[i])
    begin
      repeat (10) @(negedge core_clk);
      wait_rdy();
      // result toggle syncs in, word launches on the ninth edge
      u_asq_host.shift(32'h0, 41, rx);
      chk("streamed result", {8'h0, res_of(chs[i])},
        {8'h0, rx[31:8]});
      chk("streamed channel", chs[i], {28'h0, rx[3:0]});
      // pad the frame back to whole bytes for command decode
      u_asq_host.shift(32'h0, 7, rx);
    end
    u_asq_host.shift(32'h58, 8, rx);
    wait_rdy();
    rd_word(6, 32);
    u_asq_host.if_reset();
    wait_rdy();
    rd_word(0, 24);
    $display("test cread done");
  endtask

  // main sequence
  initial
  begin
    logic [31:0] rx;
    rst_n = 1'b0;
    n_fail = 0;
    check_count = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    u_asq_host.shift(32'h0, 3, rx);
    u_asq_host.sel(1'b0);
    t_power_up();
    t_sequence();
    t_single();
    t_cread();
    end_sim();
  end
endmodule
